// ==== logic/gpio_cd_regs.vh ====
// Register offsets, fields and reset values of the port C and D block
`ifndef GPIO_CD_REGS_VH
`define GPIO_CD_REGS_VH
// ==========================================================================
// Register offsets
`define OFS_PORT_C_DATA   8'h02
`define OFS_PORT_D_DATA   8'h03
`define OFS_PORT_C_DIR    8'h04
`define OFS_PORT_D_DIR    8'h05
`define OFS_PORT_C_PUE    8'h0C
`define OFS_PORT_D_PUE    8'h0D
`define OFS_ALT_CTRL      8'h10
// ==========================================================================
// Alternate function control fields
`define ALT_CAN_EN_BIT    0
`define ALT_SPI_EN_BIT    1
`define ALT_SPI_MSTR_BIT  2
`define ALT_TIMER1_CHANNEL0_PIN_BIT     3
`define ALT_TIMER1_CHANNEL1_PIN_BIT     4
`define ALT_TIMER2_CHANNEL0_PIN_BIT     5
`define ALT_TIMER2_CHANNEL1_PIN_BIT     6
`define ALT_CLKOUT_BIT    7
// ==========================================================================
// Reset values and port C bit mask
`define RST_DIR           8'h00
`define RST_PUE           8'h00
`define RST_ALT           8'h00
`define PORT_C_MASK       8'h7F
`endif

// ==== logic/gpio_ports_cd.v ====
// Port C and port D general-purpose I/O with alternate functions
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cd_regs.vh"
module gpio_ports_cd #(
  parameter C_WIDTH = 7,
  parameter D_WIDTH = 8
) (
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire [7:0]   addr_i,
  input  wire [7:0]   wdata_i,
  input  wire         wr_i,
  input  wire         rd_i,
  output reg  [7:0]   rdata_o,
  input  wire [7:0]   pin_c_i,
  output reg  [7:0]   pin_c_o,
  output reg  [7:0]   pin_c_oe_o,
  output reg  [7:0]   pin_c_pu_o,
  input  wire [7:0]   pin_d_i,
  output reg  [7:0]   pin_d_o,
  output reg  [7:0]   pin_d_oe_o,
  output reg  [7:0]   pin_d_pu_o,
  output reg          can_rx_o,
  input  wire         can_tx_i,
  input  wire [3:0]   tim_ch_i,
  input  wire [3:0]   tim_ch_oe_i,
  output reg  [3:0]   tim_ch_o,
  input  wire         spi_sck_i,
  input  wire         spi_sck_oe_i,
  input  wire         spi_mosi_i,
  input  wire         spi_mosi_oe_i,
  input  wire         spi_miso_i,
  input  wire         spi_miso_oe_i,
  output reg          spi_sck_o,
  output reg          spi_mosi_o,
  output reg          spi_miso_o,
  output reg          spi_ss_o,
  input  wire         clk_out_i
);
  // ========================================================================
  // Reset release
  reg        rst_s1_reg;
  reg        rst_s2_reg;
  wire       rst_n;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // ========================================================================
  // Registers
  reg  [7:0] c_data_reg;
  reg  [7:0] d_data_reg;
  reg  [7:0] c_dir_reg;
  reg  [7:0] d_dir_reg;
  reg  [7:0] c_pue_reg;
  reg  [7:0] d_pue_reg;
  reg  [7:0] alt_reg;
  wire [7:0] c_mask;
  assign c_mask = `PORT_C_MASK;

  // ========================================================================
  // Address decode
  wire       hit_c_data;
  wire       hit_d_data;
  wire       hit_c_dir;
  wire       hit_d_dir;
  wire       hit_c_pue;
  wire       hit_d_pue;
  wire       hit_alt;

  assign hit_c_data = (addr_i == `OFS_PORT_C_DATA);
  assign hit_d_data = (addr_i == `OFS_PORT_D_DATA);
  assign hit_c_dir  = (addr_i == `OFS_PORT_C_DIR);
  assign hit_d_dir  = (addr_i == `OFS_PORT_D_DIR);
  assign hit_c_pue  = (addr_i == `OFS_PORT_C_PUE);
  assign hit_d_pue  = (addr_i == `OFS_PORT_D_PUE);
  assign hit_alt    = (addr_i == `OFS_ALT_CTRL);

  // ========================================================================
  // Data latches keep contents through reset
  always @(posedge clk_i) begin
    if (wr_i && hit_c_data) begin
      c_data_reg <= wdata_i & c_mask;
    end
  end

  always @(posedge clk_i) begin
    if (wr_i && hit_d_data) begin
      d_data_reg <= wdata_i;
    end
  end

  // ========================================================================
  // Direction registers
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      c_dir_reg <= `RST_DIR;
    end else if (wr_i && hit_c_dir) begin
      c_dir_reg <= wdata_i & c_mask;
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      d_dir_reg <= `RST_DIR;
    end else if (wr_i && hit_d_dir) begin
      d_dir_reg <= wdata_i;
    end
  end

  // ========================================================================
  // Pullup enable registers
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      c_pue_reg <= `RST_PUE;
    end else if (wr_i && hit_c_pue) begin
      c_pue_reg <= wdata_i & c_mask;
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      d_pue_reg <= `RST_PUE;
    end else if (wr_i && hit_d_pue) begin
      d_pue_reg <= wdata_i;
    end
  end

  // ========================================================================
  // Alternate function control
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alt_reg <= `RST_ALT;
    end else if (wr_i && hit_alt) begin
      alt_reg <= wdata_i;
    end
  end

  // ========================================================================
  // Alternate function selects
  wire       can_en;
  wire       spi_en;
  wire       spi_mstr;
  wire       ss_used;
  wire       timer1_channel1_pin_sel;
  wire       timer1_channel0_pin_sel;
  wire       timer2_channel1_pin_sel;
  wire       timer2_channel0_pin_sel;
  wire       clk_out_sel;

  assign can_en      = alt_reg[`ALT_CAN_EN_BIT];
  assign spi_en      = alt_reg[`ALT_SPI_EN_BIT];
  assign spi_mstr    = alt_reg[`ALT_SPI_MSTR_BIT];
  assign ss_used     = spi_en & ~spi_mstr;
  assign timer1_channel1_pin_sel   = alt_reg[`ALT_TIMER1_CHANNEL1_PIN_BIT];
  assign timer1_channel0_pin_sel   = alt_reg[`ALT_TIMER1_CHANNEL0_PIN_BIT];
  assign timer2_channel1_pin_sel   = alt_reg[`ALT_TIMER2_CHANNEL1_PIN_BIT];
  assign timer2_channel0_pin_sel   = alt_reg[`ALT_TIMER2_CHANNEL0_PIN_BIT];
  assign clk_out_sel = alt_reg[`ALT_CLKOUT_BIT];

  // ========================================================================
  // Port C pin drive
  reg  [7:0] c_o_next;
  reg  [7:0] c_oe_next;
  reg  [7:0] c_pu_next;
  always @* begin
    c_o_next  = c_data_reg;
    c_oe_next = c_dir_reg;
    if (can_en) begin
      c_o_next[0]  = can_tx_i;
      c_oe_next[0] = 1'b1;
      c_oe_next[1] = 1'b0;
    end
    c_pu_next = c_pue_reg & ~c_oe_next;
  end

  // ========================================================================
  // Port D pin drive
  reg  [7:0] d_o_next;
  reg  [7:0] d_oe_next;
  reg  [7:0] d_pu_next;
  always @* begin
    d_o_next  = d_data_reg;
    d_oe_next = d_dir_reg;
    if (timer1_channel1_pin_sel) begin
      d_o_next[7]  = tim_ch_i[3];
      d_oe_next[7] = tim_ch_oe_i[3];
    end
    if (timer1_channel0_pin_sel) begin
      d_o_next[6]  = tim_ch_i[2];
      d_oe_next[6] = tim_ch_oe_i[2];
    end
    if (timer2_channel1_pin_sel) begin
      d_o_next[5]  = tim_ch_i[1];
      d_oe_next[5] = tim_ch_oe_i[1];
    end
    if (timer2_channel0_pin_sel) begin
      d_o_next[4]  = tim_ch_i[0];
      d_oe_next[4] = tim_ch_oe_i[0];
    end
    if (spi_en) begin
      d_o_next[3]  = spi_sck_i;
      d_oe_next[3] = spi_sck_oe_i;
      d_o_next[2]  = spi_mosi_i;
      d_oe_next[2] = spi_mosi_oe_i;
      d_o_next[1]  = spi_miso_i;
      d_oe_next[1] = spi_miso_oe_i;
    end
    if (ss_used) begin
      d_oe_next[0] = 1'b0;
    end else if (clk_out_sel) begin
      d_o_next[0]  = clk_out_i;
      d_oe_next[0] = 1'b1;
    end
    d_pu_next = d_pue_reg & ~d_oe_next;
  end

  // ========================================================================
  // Peripheral input selects
  wire       can_rx_next;
  wire       ss_next;
  assign can_rx_next = can_en ? pin_c_i[1] : 1'b1;
  assign ss_next     = ss_used ? pin_d_i[0] : 1'b1;

  // ========================================================================
  // Registered port C pins
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_c_o    <= 8'h00;
      pin_c_oe_o <= 8'h00;
      pin_c_pu_o <= 8'h00;
    end else begin
      pin_c_o    <= c_o_next & c_mask;
      pin_c_oe_o <= c_oe_next & c_mask;
      pin_c_pu_o <= c_pu_next & c_mask;
    end
  end

  // ========================================================================
  // Registered port D pins
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_d_o    <= 8'h00;
      pin_d_oe_o <= 8'h00;
      pin_d_pu_o <= 8'h00;
    end else begin
      pin_d_o    <= d_o_next;
      pin_d_oe_o <= d_oe_next;
      pin_d_pu_o <= d_pu_next;
    end
  end

  // ========================================================================
  // Registered peripheral inputs
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      can_rx_o   <= 1'b1;
      tim_ch_o   <= 4'h0;
      spi_sck_o  <= 1'b0;
      spi_mosi_o <= 1'b0;
      spi_miso_o <= 1'b0;
      spi_ss_o   <= 1'b1;
    end else begin
      can_rx_o   <= can_rx_next;
      tim_ch_o   <= pin_d_i[7:4];
      spi_sck_o  <= pin_d_i[3];
      spi_mosi_o <= pin_d_i[2];
      spi_miso_o <= pin_d_i[1];
      spi_ss_o   <= ss_next;
    end
  end

  // ========================================================================
  // Port read values
  wire [7:0] c_read_val;
  wire [7:0] d_read_val;
  assign c_read_val = ((c_data_reg & c_dir_reg) |
                       (pin_c_i & ~c_dir_reg)) & c_mask;
  assign d_read_val = (d_data_reg & d_dir_reg) |
                      (pin_d_i & ~d_dir_reg);

  // ========================================================================
  // Read port
  reg  [7:0] rdata_next;
  always @* begin
    rdata_next = 8'h00;
    if (hit_c_data) begin
      rdata_next = c_read_val;
    end else if (hit_d_data) begin
      rdata_next = d_read_val;
    end else if (hit_c_dir) begin
      rdata_next = c_dir_reg;
    end else if (hit_d_dir) begin
      rdata_next = d_dir_reg;
    end else if (hit_c_pue) begin
      rdata_next = c_pue_reg;
    end else if (hit_d_pue) begin
      rdata_next = d_pue_reg;
    end else if (hit_alt) begin
      rdata_next = alt_reg;
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // gpio_ports_cd
`default_nettype wire

// ==== testbench/gpio_cd_props.sv ====
// Port assertions for the port C and D block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cd_regs.vh"
module gpio_cd_props (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] pin_c_i,
  input wire logic [7:0] pin_c_o,
  input wire logic [7:0] pin_c_oe_o,
  input wire logic [7:0] pin_c_pu_o,
  input wire logic [7:0] pin_d_oe_o,
  input wire logic [7:0] pin_d_pu_o,
  input wire logic       can_rx_o,
  input wire logic       spi_ss_o
);
  // ========
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  chk_pu_c_out: assert property ((pin_c_pu_o & pin_c_oe_o) == 8'h00)
    else $error("port c pullup on output");
  chk_pu_d_out: assert property ((pin_d_pu_o & pin_d_oe_o) == 8'h00)
    else $error("port d pullup on output");
  chk_c_top_bit: assert property (
    rd_i && addr_i == `OFS_PORT_C_DATA |=> !rdata_o[7])
    else $error("port c bit 7 read high");
  chk_dir_c_oe: assert property (
    wr_i && addr_i == `OFS_PORT_C_DIR |-> ##2
    ((pin_c_oe_o ^ $past(wdata_i, 2)) & 8'h7C) == 8'h00)
    else $error("port c enable not from direction");
  chk_rst_inputs: assert property ($rose(nrst_i) |->
    ((pin_c_oe_o | pin_d_oe_o | pin_c_pu_o) == 8'h00) [*2])
    else $error("pins not inputs after reset");
  chk_rst_alt: assert property ($rose(nrst_i) |-> can_rx_o && spi_ss_o)
    else $error("alternate inputs not idle");
  chk_c_read_mux: assert property (
    rd_i && addr_i == `OFS_PORT_C_DATA |=> (rdata_o & 8'h7C) ==
    ((pin_c_oe_o & pin_c_o | ~pin_c_oe_o & $past(pin_c_i)) & 8'h7C))
    else $error("port c read source wrong");
endmodule // gpio_cd_props
bind gpio_ports_cd gpio_cd_props u_props (.clk_i, .nrst_i, .addr_i, .wr_i,
  .rd_i, .wdata_i, .rdata_o, .pin_c_i, .pin_c_o, .pin_c_oe_o, .pin_c_pu_o,
  .pin_d_oe_o, .pin_d_pu_o, .can_rx_o, .spi_ss_o);
`default_nettype wire

// ==== testbench/pin_bank.sv ====
// Pads of one port: output buffer, pullup, outside driver
`timescale 1ns/1ps
`default_nettype none
module pin_bank (
  input  wire logic       clk_i,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pu_i,
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] lvl_o
);
  logic [7:0] flt_reg = 8'h00;
  always @(posedge clk_i) flt_reg <= ~lvl_o;
  // Buffer, then outside driver, then pullup, else floating
  assign lvl_o = oe_i & drv_i | ~oe_i & (ext_en_i & ext_i |
    ~ext_en_i & (pu_i | flt_reg));
endmodule // pin_bank
`default_nettype wire

// ==== testbench/testbench.sv ====
// Register and pin scenarios for the port C and D block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cd_regs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  logic       clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic       can_tx_i = 1'b0, clk_out_i = 1'b1, can_rx_o, spi_ss_o;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, pin_c_i, pin_d_i;
  logic [7:0] pin_c_o, pin_c_oe_o, pin_c_pu_o, pin_d_o, pin_d_oe_o;
  logic [7:0] pin_d_pu_o, ext_c = 8'h00, ext_d = 8'h24;
  logic [7:0] en_c = 8'h00, en_d = 8'h00;
  logic [3:0] tim_ch_i = 4'h0, tim_ch_oe_i = 4'h0, tim_ch_o;
  logic [2:0] sd = 3'h0, se = 3'h0, si;
  int         err_count = 0, num_checks = 0;
  logic [7:0] tim_view;
  logic [8:0] spi_view;
  assign tim_view = {pin_d_oe_o[7:4], pin_d_o[7:6], tim_ch_o[1:0]};
  assign spi_view = {pin_d_oe_o[3:0], pin_d_o[1], si, spi_ss_o};
  always #25 clk_i = ~clk_i;
  gpio_ports_cd u_gpio_ports_cd (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .pin_c_i, .pin_c_o, .pin_c_oe_o, .pin_c_pu_o, .pin_d_i,
    .pin_d_o, .pin_d_oe_o, .pin_d_pu_o, .can_rx_o, .can_tx_i, .tim_ch_i,
    .tim_ch_oe_i, .tim_ch_o, .spi_sck_i(sd[2]), .spi_sck_oe_i(se[2]),
    .spi_mosi_i(sd[1]), .spi_mosi_oe_i(se[1]), .spi_miso_i(sd[0]),
    .spi_miso_oe_i(se[0]), .spi_sck_o(si[2]), .spi_mosi_o(si[1]),
    .spi_miso_o(si[0]), .spi_ss_o, .clk_out_i);
  pin_bank u_pc (.clk_i, .drv_i(pin_c_o), .oe_i(pin_c_oe_o),
    .pu_i(pin_c_pu_o), .ext_i(ext_c), .ext_en_i(en_c), .lvl_o(pin_c_i));
  pin_bank u_pd (.clk_i, .drv_i(pin_d_o), .oe_i(pin_d_oe_o),
    .pu_i(pin_d_pu_o), .ext_i(ext_d), .ext_en_i(en_d), .lvl_o(pin_d_i));
  // ========
  // Tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    `CHK(n, e, rdata_o)
  endtask
  task automatic pause;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_i);
    err_count++;
    results();
  end
  // ========
  // Scenarios
  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(`OFS_PORT_C_DIR, 8'h00, "c dir");
    rd(`OFS_PORT_D_DIR, 8'h00, "d dir");
    en_c <= 8'h7F;
    ext_c <= 8'hD5;
    wr(`OFS_PORT_C_DATA, 8'h2A);
    rd(`OFS_PORT_C_DATA, 8'h55, "c pin");
    en_c <= 8'h00;
    wr(`OFS_PORT_C_DIR, 8'hFF);
    rd(`OFS_PORT_C_DIR, 8'h7F, "c dir");
    rd(`OFS_PORT_C_DATA, 8'h2A, "c latch");
    `CHK("c drive", 8'h2A, pin_c_o & pin_c_oe_o)
    wr(`OFS_PORT_C_PUE, 8'hFF);
    wr(`OFS_PORT_C_DIR, 8'h0D);
    pause();
    `CHK("c pullup", 8'h72, pin_c_pu_o)
    en_c <= 8'h02;
    wr(`OFS_ALT_CTRL, 8'h01);
    can_tx_i <= 1'b1;
    pause();
    `CHK("can", 3'h6, {pin_c_oe_o[0], pin_c_o[0], can_rx_o})
    wr(`OFS_PORT_D_DATA, 8'hA5);
    wr(`OFS_PORT_D_PUE, 8'hFF);
    wr(`OFS_PORT_D_DIR, 8'hF0);
    en_d <= 8'h0F;
    rd(`OFS_PORT_D_DATA, 8'hA4, "d pin");
    `CHK("d pullup", 8'h0F, pin_d_pu_o)
    nrst_i <= 1'b0;
    en_d <= 8'h30;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    wr(`OFS_PORT_D_DIR, 8'hFF);
    rd(`OFS_PORT_D_DATA, 8'hA5, "d keep");
    wr(`OFS_ALT_CTRL, 8'h78);
    tim_ch_oe_i <= 4'hC;
    tim_ch_i <= 4'h9;
    ext_d <= 8'h24;
    pause();
    `CHK("timer", 8'hCA, tim_view)
    wr(`OFS_ALT_CTRL, 8'h02);
    sd <= 3'h7;
    se <= 3'h1;
    en_d <= 8'h0D;
    pause();
    `CHK("spi", 9'h056, spi_view)
    rd(`OFS_PORT_D_DATA, 8'hA5, "spi read");
    wr(`OFS_ALT_CTRL, 8'h06);
    en_d <= 8'h00;
    pause();
    `CHK("master", 2'h3, {pin_d_oe_o[0], spi_ss_o})
    wr(`OFS_ALT_CTRL, 8'h80);
    clk_out_i <= 1'b0;
    pause();
    `CHK("clock out", 5'h1E, {pin_d_oe_o[3:0], pin_d_o[0]})
    wr(8'h7E, 8'hFF);
    rd(8'h7E, 8'h00, "hole");
    results();
  end
endmodule // testbench
`default_nettype wire
